// ---- common/swire_params.svh ----
`ifndef SWIRE_PARAMS_SVH
`define SWIRE_PARAMS_SVH
// ------------------------------------------------------------
// Timing in microseconds and derived cycle counts at 100 MHz
// ------------------------------------------------------------
`define CLK_MHZ 100
`define RESET_LOW_TIME_US 480
`define RESET_DETECT_US 240
`define PRESENCE_WAIT_TIME_US 30
`define PRESENCE_LOW_TIME_US 120
`define SAMPLE_POINT_US 30
`define READ_HOLD_US 30
`define MASTER_LOW1_US 2
`define MASTER_SAMPLE_US 13
`define SLOT_TIME_US 70
`define SLOT_RECOVERY_TIME_US 5
`define RESET_LOW_CYC (`RESET_LOW_TIME_US * `CLK_MHZ)
`define RESET_DETECT_CYC (`RESET_DETECT_US * `CLK_MHZ)
`define PRESENCE_WAIT_CYC (`PRESENCE_WAIT_TIME_US * `CLK_MHZ)
`define PRESENCE_LOW_CYC (`PRESENCE_LOW_TIME_US * `CLK_MHZ)
`define SAMPLE_POINT_CYC (`SAMPLE_POINT_US * `CLK_MHZ)
`define READ_HOLD_CYC (`READ_HOLD_US * `CLK_MHZ)
`define MASTER_LOW1_CYC (`MASTER_LOW1_US * `CLK_MHZ)
`define MASTER_SAMPLE_CYC (`MASTER_SAMPLE_US * `CLK_MHZ)
`define SLOT_CYC (`SLOT_TIME_US * `CLK_MHZ)
`define RECOVERY_CYC (`SLOT_RECOVERY_TIME_US * `CLK_MHZ)
// ------------------------------------------------------------
// Selection command codes
// ------------------------------------------------------------
`define CMD_READ_ID 8'h33
`define CMD_MATCH_ID 8'h55
`define CMD_SEARCH_ID 8'hF0
`define CMD_SKIP_ID 8'hCC
`define ID_BITS 64
`endif

// ---- common/swire_pkg.sv ----
package swire_pkg;
  // Slave progress through one access
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PWAIT = 3'b001,
    S_PLOW = 3'b011,
    S_CMD = 3'b010,
    S_SEL = 3'b110,
    S_DONE = 3'b111,
    S_QUIET = 3'b101
  } slave_state_type;
  // Selection phase kinds
  typedef enum logic [1:0] {
    SEL_READ = 2'b00,
    SEL_MATCH = 2'b01,
    SEL_SEARCH = 2'b11
  } sel_kind_type;
  // Master operations
  typedef enum logic [1:0] {
    OP_RESET = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b11
  } op_type;
  // Master sequencer
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_LOW = 3'b001,
    M_WAIT = 3'b011,
    M_REC = 3'b010
  } master_state_type;
endpackage

// ---- common/swire_if.sv ----
`timescale 1ns/1ps
// Open-drain line: low whenever either end enables its pulldown
interface swire_if;
  logic slaveOe;
  logic masterOe;
  logic line;
  assign line = !(slaveOe || masterOe);
  modport slave(input line, output slaveOe);
  modport master(input line, output masterOe);
endinterface

// ---- src/swire_slave.sv ----
`timescale 1ns/1ps
`include "swire_params.svh"
// How it works
// - Slots start at master falling edge
// - Master releases line high when pausing
// - No power-on reset from long low
// - Reset, then selection, then function command
// - Reset pulse answered by presence pulse
// - Selection byte arrives LSB first
// - 33h shifts out 64-bit identity
// - Read identity only with single slave
// - 55h selects only on exact match
// - Mismatched slave waits for reset
// - F0h: bit, complement, then master write
// - CCh selects without identity
// - Slave only pulls low, never high
// - Master keeps bit rate within limit
// - Master starts all but presence
// - Master reset low at least 480us
// - Master reset low at most 960us
// - Presence: wait then pull low
// - Falling edge starts sampling delay
// - Read zero holds low, one releases
// - Master slot-open pulse at least 1us
// - Master samples within data-valid window
module swire_slave #(
  parameter logic [63:0] IDENTITY = 64'h00_0123456789AB_2A, // Arbitrary value
  parameter int RESET_DETECT = `RESET_DETECT_CYC,
  parameter int PRESENCE_WAIT = `PRESENCE_WAIT_CYC,
  parameter int PRESENCE_LOW = `PRESENCE_LOW_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  swire_if.slave bus, // Bus line
  output logic selected, // Function layer may run
  output logic [1:0] selKind // Class of the last 33h, 55h or F0h command
);
  import swire_pkg::*;

  // ------------------------------------------------------------
  // Line edge detection and low-time counter
  // ------------------------------------------------------------
  logic linePrev;
  logic [19:0] lowCnt;
  logic [19:0] tmr;
  slave_state_type state;
  logic [7:0] cmd;
  logic [6:0] bitIdx;
  logic [1:0] phase; // Search step: 0 bit, 1 complement, 2 write
  logic inSlot;
  logic driving;
  logic lowSeen;
  wire fallEdge = linePrev && !bus.line;
  wire riseEdge = !linePrev && bus.line;
  wire resetSeen = lowSeen && riseEdge;
  wire idBit = IDENTITY[bitIdx[5:0]];
  wire sampleNow = inSlot && (tmr == 20'(`SAMPLE_POINT_CYC));
  wire holdDone = inSlot && (tmr == 20'(`READ_HOLD_CYC));
  wire talkRead = (state == S_SEL) && (selKind == SEL_READ);
  wire talkSrch = (state == S_SEL) && (selKind == SEL_SEARCH) && (phase != 2'd2);
  wire srchVal = (phase == 2'd0) ? idBit : !idBit;
  wire txBit = talkRead ? idBit : srchVal;
  wire txZero = (talkRead || talkSrch) && !txBit;

  // Long-low detection; only a line reset, never a power-on style reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linePrev <= 1'b1;
      lowCnt <= '0;
      lowSeen <= 1'b0;
    end else begin
      linePrev <= bus.line;
      lowCnt <= bus.line ? '0 : lowCnt + 20'd1;
      if (bus.line) lowSeen <= 1'b0;
      else if (lowCnt >= 20'(RESET_DETECT)) lowSeen <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Pulldown: the only drive this end ever makes
  // ------------------------------------------------------------
  assign bus.slaveOe = driving;

  // ------------------------------------------------------------
  // Protocol sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      tmr <= '0;
      cmd <= 8'h00;
      bitIdx <= '0;
      phase <= 2'd0;
      inSlot <= 1'b0;
      driving <= 1'b0;
      selected <= 1'b0;
      selKind <= SEL_READ;
    end else if (resetSeen) begin
      state <= S_PWAIT;
      tmr <= '0;
      bitIdx <= '0;
      phase <= 2'd0;
      inSlot <= 1'b0;
      driving <= 1'b0;
      selected <= 1'b0;
    end else begin
      tmr <= tmr + 20'd1;
      case (state)
        S_PWAIT: if (tmr == 20'(PRESENCE_WAIT)) begin
          state <= S_PLOW;
          driving <= 1'b1;
          tmr <= '0;
        end
        S_PLOW: if (tmr == 20'(PRESENCE_LOW)) begin
          state <= S_CMD;
          driving <= 1'b0;
        end
        S_CMD, S_SEL: begin
          if (fallEdge && !driving) begin
            inSlot <= 1'b1;
            tmr <= '0;
            if (state == S_SEL && txZero) driving <= 1'b1;
          end
          if (holdDone) driving <= 1'b0;
          if (sampleNow) begin
            inSlot <= 1'b0;
            if (state == S_CMD) begin
              cmd <= {bus.line, cmd[7:1]};
              bitIdx <= bitIdx + 7'd1;
              if (bitIdx == 7'd7) begin
                bitIdx <= '0;
                case ({bus.line, cmd[7:1]})
                  `CMD_READ_ID: begin state <= S_SEL; selKind <= SEL_READ; end
                  `CMD_MATCH_ID: begin state <= S_SEL; selKind <= SEL_MATCH; end
                  `CMD_SEARCH_ID: begin state <= S_SEL; selKind <= SEL_SEARCH; end
                  `CMD_SKIP_ID: begin state <= S_DONE; selected <= 1'b1; end
                  default: state <= S_QUIET;
                endcase
              end
            end else if (selKind == SEL_SEARCH && phase != 2'd2) begin
              phase <= phase + 2'd1;
            end else begin
              phase <= 2'd0;
              if (selKind != SEL_READ && bus.line != idBit) begin
                state <= S_QUIET;
              end else if (bitIdx == 7'(`ID_BITS - 1)) begin
                state <= S_DONE;
                selected <= 1'b1;
              end else begin
                bitIdx <= bitIdx + 7'd1;
              end
            end
          end
        end
        S_DONE, S_QUIET, S_IDLE: driving <= 1'b0; // Wait for next reset
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- src/swire_master.sv ----
`timescale 1ns/1ps
`include "swire_params.svh"
// Bus master end: one operation per request, pulldown only
module swire_master #(
  parameter int RESET_LOW = `RESET_LOW_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  swire_if.master bus, // Bus line
  input wire logic reqValid, // Start operation
  input wire swire_pkg::op_type reqOp, // Reset, write bit, read bit
  input wire logic reqBit, // Bit to write
  output logic reqReady, // Idle, may take request
  output logic doneValid, // One-cycle completion pulse
  output logic doneBit // Read bit or presence seen
);
  import swire_pkg::*;

  master_state_type state;
  op_type op;
  logic wbit;
  logic [19:0] tmr;
  logic drive;
  logic presence;

  // ------------------------------------------------------------
  // Phase lengths per operation
  // ------------------------------------------------------------
  wire [19:0] lowLen = (op == OP_RESET) ? 20'(RESET_LOW) :
    ((op == OP_WRITE && !wbit) ? 20'(`SLOT_CYC) : 20'(`MASTER_LOW1_CYC));
  wire [19:0] waitLen = (op == OP_RESET) ? 20'(RESET_LOW) :
    ((op == OP_WRITE && !wbit) ? 20'd1 : 20'(`SLOT_CYC - `MASTER_LOW1_CYC));
  wire samplePt = (op == OP_READ) && (tmr == 20'(`MASTER_SAMPLE_CYC - `MASTER_LOW1_CYC));

  assign reqReady = (state == M_IDLE);
  assign bus.masterOe = drive;

  // Sequencer; recovery keeps the bit rate under the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= M_IDLE;
      op <= OP_RESET;
      wbit <= 1'b1;
      tmr <= '0;
      drive <= 1'b0;
      presence <= 1'b0;
      doneValid <= 1'b0;
      doneBit <= 1'b0;
    end else begin
      doneValid <= 1'b0;
      tmr <= tmr + 20'd1;
      case (state)
        M_IDLE: if (reqValid) begin
          state <= M_LOW;
          op <= reqOp;
          wbit <= reqBit;
          drive <= 1'b1;
          tmr <= '0;
          presence <= 1'b0;
        end
        M_LOW: if (tmr == lowLen) begin // lowLen + 1 cycles, never one short
          state <= M_WAIT;
          drive <= 1'b0;
          tmr <= '0;
        end
        M_WAIT: begin
          if (samplePt) doneBit <= bus.line;
          if (op == OP_RESET && !bus.line) presence <= 1'b1;
          if (tmr == waitLen - 20'd1) begin
            state <= M_REC;
            tmr <= '0;
          end
        end
        M_REC: if (tmr == 20'(`RECOVERY_CYC - 1)) begin
          state <= M_IDLE;
          doneValid <= 1'b1;
          if (op == OP_RESET) doneBit <= presence;
        end
        default: state <= M_IDLE;
      endcase
    end
  end
endmodule

// ---- tb/swire_link_chk.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Line timing checker
// ------------------------------------------------------------
module swire_link_chk #(
  parameter int RESET_LOW = 10000
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic slaveOe, // Slave pulldown
  input wire logic masterOe, // Master pulldown
  input wire logic line // Wired level
);
  int mLow;
  int mIdle;
  int sLow;
  int mGap;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Run lengths; idle and gap counts saturate so a long idle cannot wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mLow <= 0;
      mIdle <= 0;
      sLow <= 0;
      mGap <= 100000;
    end else begin
      mLow <= masterOe ? mLow + 1 : 0;
      mIdle <= masterOe ? 0 : (mIdle < 100000 ? mIdle + 1 : mIdle);
      sLow <= slaveOe ? sLow + 1 : 0;
      // Cycles since the master last opened a slot or reset
      mGap <= (masterOe && mLow == 0) ? 1 : (mGap < 100000 ? mGap + 1 : mGap);
    end
  end
  wired_and_a: assert property (line == !(slaveOe || masterOe))
    else $error("line level wrong");
  short_pulse_a: assert property ($fell(masterOe) |-> mLow >= 100)
    else $error("slot pulse too short");
  pulse_kind_a: assert property ($fell(masterOe) |-> mLow <= 7100 || mLow >= RESET_LOW)
    else $error("reset pulse too short");
  reset_max_a: assert property (mLow <= 96000)
    else $error("line held low too long");
  presence_win_a: assert property ($rose(slaveOe) |-> masterOe || mIdle inside {[1500:6000]})
    else $error("slave pull outside slot or presence window");
  slave_pulse_a: assert property ($fell(slaveOe) |->
    sLow inside {[2900:3100]} || sLow inside {[6000:24000]})
    else $error("slave pull length wrong");
  quiet_reset_a: assert property (masterOe && mLow > 7100 |-> !slaveOe)
    else $error("slave pulls during reset");
  slot_open_a: assert property ($rose(slaveOe) && masterOe |-> mLow < 200)
    else $error("slave answer late in slot");
  // 16.3 kbit/s means at least 6135 cycles from one slot start to the next
  rate_limit_a: assert property ($rose(masterOe) |-> mGap >= 6135)
    else $error("master slots too close together");
endmodule

// ---- tb/single_wire_slave_rom_layer_bench.sv ----
`timescale 1ns/1ps
`include "swire_params.svh"
module single_wire_slave_rom_layer_bench;
  import swire_pkg::*;
  typedef struct packed {
    op_type op;
    logic b;
    logic chk;
    logic exp;
  } row_type;
  // Arbitrary identity: bit 0 low, bit 1 high so both read levels show
  localparam logic [63:0] ID = 64'h0000_0000_0000_00A2;
  localparam logic [7:0] CMD = `CMD_READ_ID;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic reqValid = 1'h0;
  op_type reqOp = OP_RESET;
  logic reqBit = 1'h0;
  logic reqReady, doneValid, doneBit, selected, got;
  logic [1:0] selKind;
  int nFail = 0;
  int comparisons = 0;
  row_type rows [11];
  swire_if link();
  // Reset detect sits above the 70us write-0 low so data is never a reset
  swire_slave #(.IDENTITY(ID), .RESET_DETECT(8000), .PRESENCE_WAIT(2000),
    .PRESENCE_LOW(6500)) i_swire_slave (.clk(clk), .rst(rst), .bus(link),
    .selected(selected), .selKind(selKind));
  swire_master #(.RESET_LOW(10000)) i_swire_master (.clk(clk), .rst(rst), .bus(link),
    .reqValid(reqValid), .reqOp(reqOp), .reqBit(reqBit), .reqReady(reqReady),
    .doneValid(doneValid), .doneBit(doneBit));
  swire_link_chk #(.RESET_LOW(10000)) i_swire_link_chk (.clk(clk), .rst(rst),
    .slaveOe(link.slaveOe), .masterOe(link.masterOe), .line(link.line));
  always #5 clk = ~clk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [1:0] seen, input logic [1:0] want);
    comparisons++;
    if (seen !== want) begin
      nFail++;
      $display("ERROR %0t: saw %b want %b", $time, seen, want);
    end
  endtask
  // One master operation; bounded wait so a lost pulse cannot hang
  task automatic doOp(input op_type op, input logic b);
    int n;
    n = 0;
    @(posedge clk);
    reqOp <= op;
    reqBit <= b;
    reqValid <= 1'h1;
    @(posedge clk);
    reqValid <= 1'h0;
    while (doneValid !== 1'h1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    check({1'h0, n < 30000}, 2'h1);
    got = doneBit;
  endtask
  task automatic conclude;
    $display("%0d compares, %0d mismatches", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rows[0] = '{OP_RESET, 1'h0, 1'h1, 1'h1};
    for (int i = 0; i < 8; i++) rows[1 + i] = '{OP_WRITE, CMD[i], 1'h0, 1'h0};
    rows[9] = '{OP_READ, 1'h0, 1'h1, ID[0]};
    rows[10] = '{OP_READ, 1'h0, 1'h1, ID[1]};
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check({link.masterOe, link.slaveOe}, 2'h0);
    check({reqReady, selected}, 2'h2);
    $display("reset test done");
    // Presence, read-identity byte LSB first, first identity bits
    foreach (rows[i]) begin
      doOp(rows[i].op, rows[i].b);
      if (rows[i].chk) check({1'h0, got}, {1'h0, rows[i].exp});
    end
    check(selKind, SEL_READ);
    $display("row test done");
    // Reset in mid identity read: presence again, selection dropped
    doOp(OP_RESET, 1'h0);
    check({selected, got}, 2'h1);
    $display("abort test done");
    conclude();
  end
  // Run is about 1.2 ms of traffic; margin covers one slow operation
  initial begin
    #1500000;
    nFail++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end
endmodule
